// ---- core/phy_mgmt_pkg.sv ----
package phy_mgmt_pkg;

   // ------------------------------------------------------------
   // Management register numbers
   // ------------------------------------------------------------
   localparam logic [4:0] REG_SPEED_CFG = 5'h14;
   localparam logic [4:0] REG_RX_ERR = 5'h15;
   localparam logic [4:0] REG_EXT_ADDR = 5'h1E;
   localparam logic [4:0] REG_EXTENDED_DATA_PORT = 5'h1F;

   // ------------------------------------------------------------
   // Extended register addresses
   // ------------------------------------------------------------
   localparam logic [15:0] EXT_TEN_MEG_PWR = 16'h200A;
   localparam logic [15:0] EXT_COMBO_CTRL = 16'h4000;
   localparam logic [15:0] EXT_PAD_CTRL = 16'h4001;

   // ------------------------------------------------------------
   // Reset values and write masks
   // ------------------------------------------------------------
   localparam logic [15:0] SPEED_CFG_RST = 16'h082C;
   localparam logic [15:0] SPEED_CFG_WMASK = 16'h0FFE;
   localparam logic [15:0] TEN_MEG_PWR_RST = 16'hCA02;
   localparam logic [15:0] COMBO_CTRL_RST = 16'h0000;
   localparam logic [15:0] PAD_CTRL_RST = 16'h80EF;
   localparam logic [15:0] RX_ERR_MAX = 16'hFFFF;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int READ_LATCH_BIT = 11;
   localparam int DG_ENABLE_BIT = 5;
   localparam int DG_COUNT_LSB = 2;
   localparam int TIMER_BYPASS_BIT = 1;
   localparam int IDLE_DAC_OFF_BIT = 10;
   localparam int REMOTE_LOOP_BIT = 11;
   localparam int JUMBO_BIT = 5;
   localparam int CRS_DV_SEL_BIT = 4;
   localparam int WAKE_EN_BIT = 2;
   localparam int REDUCED_EN_BIT = 1;
   localparam int CLK_DIR_BIT = 0;
   localparam int INT_SRC_BIT = 15;
   localparam logic [2:0] DG_COUNT_RST = 3'h3;
   localparam logic [3:0] DG_EXTRA_TRIES = 4'h2;

   // ------------------------------------------------------------
   // Frame sizes in bytes
   // ------------------------------------------------------------
   localparam logic [14:0] FRAME_MAX_LARGE = 15'h4800;
   localparam logic [14:0] FRAME_MAX_SMALL = 15'h1200;

   // ------------------------------------------------------------
   // Management frame layout
   // ------------------------------------------------------------
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [3:0] HEADER_LAST = 4'hC;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] WRITE_LAST = 5'h11;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ = 50000;
   localparam int STABLE_TIME_MS = 2500;
   localparam int STABLE_CYC = STABLE_TIME_MS * CLK_KHZ;
   localparam logic [1:0] STRAP_TAKE = 2'h2;
   localparam logic [1:0] STRAP_DONE = 2'h3;

endpackage

// ---- core/phy_mgmt_config_regs.sv ----
// Operation
// - Bit 11 latches read value during frame
// - Downgrade enable bit applies after soft reset
// - Attempts equal count field plus two
// - New attempt count waits for soft reset
// - Bypass bit skips link stability timer
// - Short link counts failure, retry increments
// - Receive error counter saturates at 0xFFFF
// - Register 0x1E holds extended address
// - Register 0x1F is extended data port
// - Ten-meg idle bit gates transmit DAC
// - Combo register: remote loopback, wake enable
// - Large frame bit selects 18KB or 4.5KB
// - Reduced mode carrier pin source select
// - Clock direction strap and interface mode
// - Pad bit 15 picks general or wake interrupt for light when strapped
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_config_regs
   import phy_mgmt_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = STABLE_CYC
) (
   input wire logic clk_sys, // 50 MHz clock
   input wire logic rstn, // Async reset, active low
   input wire logic [4:0] phy_addr, // Station address of this port
   input wire logic mdc, // Management clock pin
   input wire logic mdio_in, // Management data pin, input
   output logic mdio_out, // Management data pin, output
   output logic mdio_oe_n, // Low while driving data pin
   input wire logic clk_dir_strap, // Clock direction strap pin
   input wire logic second_receive_data_pin, // Interrupt routing strap
   input wire logic soft_reset, // Software reset pulse
   input wire logic link_up, // Link established level
   input wire logic an_fail, // Negotiation attempt failed pulse
   input wire logic rx_error, // Receive error event pulse
   input wire logic speed_10m, // Link runs at 10 Mb/s
   input wire logic tx_pending, // Data or link pulse to send
   input wire logic rx_dv, // Internal receive data valid
   input wire logic crs_dv, // Internal carrier/data valid
   input wire logic gen_irq, // General interrupt
   input wire logic wake_irq, // Wake interrupt
   input wire logic led_status, // Normal light drive
   output logic speed_downgrade, // Fallback to lower speed
   output logic tx_dac_on, // Transmit DAC enable
   output logic remote_loopback, // Remote loopback enable
   output logic wake_packet_enable, // Wake-on-LAN enable
   output logic [14:0] max_frame_len, // Largest frame in bytes
   output logic crs_dv_pin, // Carrier/data valid pad
   output logic clk_dir_input, // Clocks are inputs
   output logic reduced_mode_one, // First reduced mode
   output logic reduced_mode_two, // Second reduced mode
   output logic first_status_light_pin // Shared light pad
);

   typedef enum logic [2:0] {M_IDLE, M_HDR, M_TA, M_RDATA, M_WDATA} mgmt_t;
   typedef enum logic [1:0] {D_WAIT, D_CHECK, D_UP} dg_t;

   logic [2:0] mdc_sync_ff;
   logic [1:0] mdio_sync_ff, dir_sync_ff, rxd1_sync_ff;
   logic [1:0] strap_cnt_ff;
   logic int_route_ff;
   logic mdc_rise;
   logic bit_in;
   mgmt_t mstate_ff;
   logic [5:0] pre_cnt_ff;
   logic [4:0] bit_cnt_ff;
   logic [15:0] shift_ff, rd_hold_ff, rd_live;
   logic [4:0] reg_sel_ff;
   logic [15:0] speed_cfg_ff, rx_err_ff, ext_addr_ff;
   logic [15:0] pwr_ctrl_ff, combo_ff, pad_ff;
   logic wr_stb;
   logic [15:0] wr_data;
   logic dg_en_act_ff;
   logic [2:0] dg_cnt_act_ff;
   dg_t dstate_ff;
   logic [3:0] retry_ff;
   logic [26:0] stab_ff;
   logic speed_downgrade_ff, tx_dac_on_ff, crs_dv_pin_ff;
   logic light_ff, mdio_out_ff, mdio_oe_n_ff;
   logic mode_one_ff, mode_two_ff;
   logic [14:0] frame_len_ff;

   // Bit of a read word chosen by position
   function automatic logic pick(input logic [15:0] w, input logic [4:0] i);
      return w[i[3:0]];
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers and strap capture
   // ------------------------------------------------------------
   // Two stages per pin; the third mdc stage feeds edge detection
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mdc_sync_ff <= 3'h0;
         mdio_sync_ff <= 2'h0;
         dir_sync_ff <= 2'h0;
         rxd1_sync_ff <= 2'h0;
      end else begin
         mdc_sync_ff <= {mdc_sync_ff[1:0], mdc};
         mdio_sync_ff <= {mdio_sync_ff[0], mdio_in};
         dir_sync_ff <= {dir_sync_ff[0], clk_dir_strap};
         rxd1_sync_ff <= {rxd1_sync_ff[0], second_receive_data_pin};
      end
   end

   assign mdc_rise = mdc_sync_ff[1] & ~mdc_sync_ff[2];
   assign bit_in = mdio_sync_ff[1];

   // Straps are taken once the synchronisers hold the pin, not reset zeros
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strap_cnt_ff <= 2'h0;
         int_route_ff <= 1'b0;
      end else if (strap_cnt_ff != STRAP_DONE) begin
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         if (strap_cnt_ff == STRAP_TAKE) int_route_ff <= rxd1_sync_ff[1];
      end
   end

   // ------------------------------------------------------------
   // Register read mux
   // ------------------------------------------------------------
   // Data port returns the extended register under the pointer
   always_comb begin
      rd_live = 16'h0000;
      unique case (reg_sel_ff)
         REG_SPEED_CFG: rd_live = speed_cfg_ff;
         REG_RX_ERR: rd_live = rx_err_ff;
         REG_EXT_ADDR: rd_live = ext_addr_ff;
         REG_EXTENDED_DATA_PORT: begin
            if (ext_addr_ff == EXT_TEN_MEG_PWR) rd_live = pwr_ctrl_ff;
            else if (ext_addr_ff == EXT_COMBO_CTRL) rd_live = combo_ff;
            else if (ext_addr_ff == EXT_PAD_CTRL) rd_live = pad_ff;
         end
         default: rd_live = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Management frame engine
   // ------------------------------------------------------------
   // Write commits on the last data bit of a matching write frame
   assign wr_stb = mdc_rise && mstate_ff == M_WDATA &&
                   bit_cnt_ff == WRITE_LAST;
   assign wr_data = {shift_ff[14:0], bit_in};

   // Bits move on synchronised mdc rising edges only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mstate_ff <= M_IDLE;
         pre_cnt_ff <= 6'h00;
         bit_cnt_ff <= 5'h00;
         shift_ff <= 16'h0000;
         reg_sel_ff <= 5'h00;
         rd_hold_ff <= 16'h0000;
         mdio_out_ff <= 1'b1;
         mdio_oe_n_ff <= 1'b1;
      end else if (mdc_rise) begin
         unique case (mstate_ff)
            M_IDLE: begin
               if (bit_in) begin
                  if (pre_cnt_ff != PREAMBLE_BITS)
                     pre_cnt_ff <= pre_cnt_ff + 6'h01;
               end else if (pre_cnt_ff == PREAMBLE_BITS) begin
                  mstate_ff <= M_HDR;
                  bit_cnt_ff <= 5'h00;
               end else begin
                  pre_cnt_ff <= 6'h00;
               end
            end
            M_HDR: begin
               shift_ff <= {shift_ff[14:0], bit_in};
               bit_cnt_ff <= bit_cnt_ff + 5'h01;
               if (bit_cnt_ff[3:0] == HEADER_LAST) begin
                  pre_cnt_ff <= 6'h00;
                  bit_cnt_ff <= 5'h00;
                  reg_sel_ff <= {shift_ff[3:0], bit_in};
                  if (!shift_ff[11] || shift_ff[8:4] != phy_addr)
                     mstate_ff <= M_IDLE;
                  else if (shift_ff[10:9] == OP_READ)
                     mstate_ff <= M_TA;
                  else if (shift_ff[10:9] == OP_WRITE)
                     mstate_ff <= M_WDATA;
                  else
                     mstate_ff <= M_IDLE;
               end
            end
            M_TA: begin
               // First turnaround bit left floating, second driven low
               mdio_oe_n_ff <= 1'b0;
               mdio_out_ff <= 1'b0;
               mstate_ff <= M_RDATA;
               bit_cnt_ff <= 5'h10;
               rd_hold_ff <= rd_live;
            end
            M_RDATA: begin
               if (bit_cnt_ff == 5'h00) begin
                  mdio_oe_n_ff <= 1'b1;
                  mdio_out_ff <= 1'b1;
                  mstate_ff <= M_IDLE;
               end else begin
                  bit_cnt_ff <= bit_cnt_ff - 5'h01;
                  // Latched word or live value per bit
                  if (speed_cfg_ff[READ_LATCH_BIT])
                     mdio_out_ff <= pick(rd_hold_ff, bit_cnt_ff - 5'h01);
                  else
                     mdio_out_ff <= pick(rd_live, bit_cnt_ff - 5'h01);
               end
            end
            M_WDATA: begin
               shift_ff <= {shift_ff[14:0], bit_in};
               bit_cnt_ff <= bit_cnt_ff + 5'h01;
               if (bit_cnt_ff == WRITE_LAST) mstate_ff <= M_IDLE;
            end
            default: mstate_ff <= M_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   // Host writes; clock direction bit loads from the strap
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         speed_cfg_ff <= SPEED_CFG_RST;
         ext_addr_ff <= 16'h0000;
         pwr_ctrl_ff <= TEN_MEG_PWR_RST;
         combo_ff <= COMBO_CTRL_RST;
         pad_ff <= PAD_CTRL_RST;
      end else begin
         if (strap_cnt_ff == STRAP_TAKE)
            combo_ff[CLK_DIR_BIT] <= dir_sync_ff[1];
         if (wr_stb) begin
            unique case (reg_sel_ff)
               REG_SPEED_CFG: speed_cfg_ff <= (wr_data & SPEED_CFG_WMASK) |
                  (speed_cfg_ff & ~SPEED_CFG_WMASK);
               REG_EXT_ADDR: ext_addr_ff <= wr_data;
               REG_EXTENDED_DATA_PORT: begin
                  if (ext_addr_ff == EXT_TEN_MEG_PWR) pwr_ctrl_ff <= wr_data;
                  else if (ext_addr_ff == EXT_COMBO_CTRL) combo_ff <= wr_data;
                  else if (ext_addr_ff == EXT_PAD_CTRL) pad_ff <= wr_data;
               end
               default: ;
            endcase
         end
      end
   end

   // Receive error tally holds at its top value
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) rx_err_ff <= 16'h0000;
      else if (rx_error && rx_err_ff != RX_ERR_MAX)
         rx_err_ff <= rx_err_ff + 16'h0001;
   end

   // ------------------------------------------------------------
   // Speed downgrade
   // ------------------------------------------------------------
   // Enable and attempt count take effect only at software reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dg_en_act_ff <= SPEED_CFG_RST[DG_ENABLE_BIT];
         dg_cnt_act_ff <= DG_COUNT_RST;
      end else if (soft_reset) begin
         dg_en_act_ff <= speed_cfg_ff[DG_ENABLE_BIT];
         dg_cnt_act_ff <= speed_cfg_ff[DG_COUNT_LSB +: 3];
      end
   end

   // Failed attempts count up; reaching count plus two falls back
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dstate_ff <= D_WAIT;
         retry_ff <= 4'h0;
         stab_ff <= 27'h0;
         speed_downgrade_ff <= 1'b0;
      end else if (soft_reset) begin
         dstate_ff <= D_WAIT;
         retry_ff <= 4'h0;
         speed_downgrade_ff <= 1'b0;
      end else begin
         if ((dstate_ff == D_WAIT && an_fail && !link_up) ||
             (dstate_ff == D_CHECK && !link_up)) begin
            if (dg_en_act_ff && retry_ff + 4'h1 ==
                {1'b0, dg_cnt_act_ff} + DG_EXTRA_TRIES) begin
               speed_downgrade_ff <= 1'b1;
               retry_ff <= 4'h0;
            end else begin
               retry_ff <= retry_ff + 4'h1;
            end
         end
         unique case (dstate_ff)
            D_WAIT: begin
               stab_ff <= 27'h0;
               if (link_up && speed_cfg_ff[TIMER_BYPASS_BIT]) begin
                  dstate_ff <= D_UP;
                  retry_ff <= 4'h0;
               end else if (link_up) begin
                  dstate_ff <= D_CHECK;
               end
            end
            D_CHECK: begin
               if (!link_up) begin
                  dstate_ff <= D_WAIT;
               end else if (stab_ff == 27'(STABLE_CYCLES - 1)) begin
                  dstate_ff <= D_UP;
                  retry_ff <= 4'h0;
               end else begin
                  stab_ff <= stab_ff + 27'h1;
               end
            end
            D_UP: if (!link_up) dstate_ff <= D_WAIT;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pad and datapath controls
   // ------------------------------------------------------------
   // DAC, carrier pad and shared light are registered
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tx_dac_on_ff <= 1'b1;
         crs_dv_pin_ff <= 1'b0;
         light_ff <= 1'b0;
         mode_one_ff <= 1'b0;
         mode_two_ff <= 1'b0;
         frame_len_ff <= FRAME_MAX_SMALL;
      end else begin
         tx_dac_on_ff <= !(speed_10m && pwr_ctrl_ff[IDLE_DAC_OFF_BIT] &&
                           !tx_pending);
         if (combo_ff[REDUCED_EN_BIT] && combo_ff[CRS_DV_SEL_BIT])
            crs_dv_pin_ff <= rx_dv;
         else
            crs_dv_pin_ff <= crs_dv;
         if (!int_route_ff) light_ff <= led_status;
         else if (pad_ff[INT_SRC_BIT]) light_ff <= gen_irq;
         else light_ff <= wake_irq;
         // Mode and frame limit outputs leave from flops
         mode_one_ff <= combo_ff[REDUCED_EN_BIT] & combo_ff[CLK_DIR_BIT];
         mode_two_ff <= combo_ff[REDUCED_EN_BIT] & ~combo_ff[CLK_DIR_BIT];
         frame_len_ff <= combo_ff[JUMBO_BIT] ? FRAME_MAX_LARGE
                                             : FRAME_MAX_SMALL;
      end
   end

   assign speed_downgrade = speed_downgrade_ff;
   assign tx_dac_on = tx_dac_on_ff;
   assign crs_dv_pin = crs_dv_pin_ff;
   assign first_status_light_pin = light_ff;
   assign mdio_out = mdio_out_ff;
   assign mdio_oe_n = mdio_oe_n_ff;
   // Enable and clock direction outputs are register bits
   assign remote_loopback = combo_ff[REMOTE_LOOP_BIT];
   assign wake_packet_enable = combo_ff[WAKE_EN_BIT];
   assign max_frame_len = frame_len_ff;
   assign clk_dir_input = combo_ff[CLK_DIR_BIT];
   assign reduced_mode_one = mode_one_ff;
   assign reduced_mode_two = mode_two_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   err_sat_a: assert property (rx_err_ff == RX_ERR_MAX |=>
      rx_err_ff == RX_ERR_MAX) else $error("error tally wrapped");
   err_inc_a: assert property (rx_error && rx_err_ff != RX_ERR_MAX |=>
      rx_err_ff == $past(rx_err_ff) + 16'h0001) else $error("tally missed");
   dg_hold_a: assert property (!soft_reset |=>
      $stable(dg_cnt_act_ff) && $stable(dg_en_act_ff))
      else $error("downgrade setting moved without reset");
   dg_load_a: assert property (soft_reset |=>
      dg_en_act_ff == $past(speed_cfg_ff[DG_ENABLE_BIT]))
      else $error("downgrade enable not loaded");
   bypass_up_a: assert property (dstate_ff == D_WAIT && link_up &&
      speed_cfg_ff[TIMER_BYPASS_BIT] && !soft_reset |=> dstate_ff == D_UP)
      else $error("bypass did not skip timer");
   short_link_a: assert property (dstate_ff == D_CHECK && !link_up &&
      !soft_reset && !speed_downgrade_ff && !dg_en_act_ff |=>
      retry_ff == $past(retry_ff) + 4'h1) else $error("retry not counted");
   dac_off_a: assert property (speed_10m && !tx_pending &&
      pwr_ctrl_ff[IDLE_DAC_OFF_BIT] |=> !tx_dac_on) else $error("dac on");
   crs_src_a: assert property (combo_ff[REDUCED_EN_BIT] &&
      combo_ff[CRS_DV_SEL_BIT] |=> crs_dv_pin == $past(rx_dv))
      else $error("carrier pad source wrong");
   latch_a: assert property (mstate_ff == M_RDATA &&
      speed_cfg_ff[READ_LATCH_BIT] |=> $stable(rd_hold_ff))
      else $error("read latch changed in frame");
   ptr_keep_a: assert property (wr_stb && reg_sel_ff == REG_EXTENDED_DATA_PORT
      |=> $stable(ext_addr_ff)) else $error("pointer moved");
   read_cv: cover property (mstate_ff == M_TA ##1 mstate_ff == M_RDATA);
   write_cv: cover property (wr_stb && reg_sel_ff == REG_EXTENDED_DATA_PORT);
   downgrade_cv: cover property (!speed_downgrade_ff ##1 speed_downgrade_ff);

endmodule // phy_mgmt_config_regs
`default_nettype wire

// ---- verification/mdio_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Management host: makes mdc and its own side of the data line
module mdio_host_model
   import phy_mgmt_pkg::*;
#(
   parameter int HALF = 8
) (
   input wire logic clk_sys, // System clock
   input wire logic mdio_out, // Device data
   input wire logic mdio_oe_n, // Device drive enable, active low
   output logic mdc, // Management clock, still between frames
   output logic mdio_in // Resolved data line
);
   logic drv_ff;
   logic bit_ff;

   // Line with pull-up: host, device, else the pull-up level
   assign mdio_in = drv_ff ? bit_ff : (mdio_oe_n ? 1'b1 : mdio_out);

   // Idle: clock low, line released
   initial begin
      mdc = 1'b0;
      drv_ff = 1'b0;
      bit_ff = 1'b1;
   end

   // One frame, fresh preamble, released during turnaround on reads
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] bits;
      bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      @(posedge clk_sys);
      #1;
      for (int i = 64; i >= 0; i--) begin
         mdc = 1'b0;
         drv_ff = (i > 0) && (op == OP_WRITE || i > 18);
         if (i > 0) bit_ff = bits[i-1];
         repeat (HALF) @(posedge clk_sys);
         #1;
         if (i > 0) rd = {rd[14:0], mdio_in};
         mdc = 1'b1;
         repeat (HALF) @(posedge clk_sys);
         #1;
      end
      mdc = 1'b0;
      drv_ff = 1'b0;
   endtask
endmodule // mdio_host_model
`default_nettype wire

// ---- verification/phy_mgmt_config_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_config_regs_tb;
   import phy_mgmt_pkg::*;
   localparam logic [4:0] PHY_ID = 5'h05;
   logic clk_sys = 1'b0;
   logic rstn, mdc, mdio_in, mdio_out, mdio_oe_n, clk_dir_strap;
   logic second_receive_data_pin, soft_reset, link_up, an_fail, rx_error;
   logic speed_10m, tx_pending, rx_dv, crs_dv, gen_irq, wake_irq;
   logic led_status, speed_downgrade, tx_dac_on, remote_loopback;
   logic wake_packet_enable, crs_dv_pin, clk_dir_input, reduced_mode_one;
   logic reduced_mode_two, first_status_light_pin;
   logic [14:0] max_frame_len;
   logic [15:0] r, v, dummy;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   integer seed = 32'h63c6e74d;

   phy_mgmt_config_regs #(.STABLE_CYCLES(20)) dut_u (
      .clk_sys(clk_sys), .rstn(rstn), .phy_addr(PHY_ID), .mdc(mdc),
      .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
      .clk_dir_strap(clk_dir_strap),
      .second_receive_data_pin(second_receive_data_pin),
      .soft_reset(soft_reset), .link_up(link_up), .an_fail(an_fail),
      .rx_error(rx_error), .speed_10m(speed_10m), .tx_pending(tx_pending),
      .rx_dv(rx_dv), .crs_dv(crs_dv), .gen_irq(gen_irq),
      .wake_irq(wake_irq), .led_status(led_status),
      .speed_downgrade(speed_downgrade), .tx_dac_on(tx_dac_on),
      .remote_loopback(remote_loopback),
      .wake_packet_enable(wake_packet_enable),
      .max_frame_len(max_frame_len), .crs_dv_pin(crs_dv_pin),
      .clk_dir_input(clk_dir_input), .reduced_mode_one(reduced_mode_one),
      .reduced_mode_two(reduced_mode_two),
      .first_status_light_pin(first_status_light_pin));

   mdio_host_model host_u (.clk_sys(clk_sys), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));

   // ------------------------------------------------------------
   // Clock, hang limit and helpers
   // ------------------------------------------------------------
   always #10 clk_sys = ~clk_sys;

   // Cut a hang short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic clks(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      host_u.frame(OP_WRITE, PHY_ID, ra, d, dummy);
   endtask

   task automatic rdr(input logic [4:0] ra);
      host_u.frame(OP_READ, PHY_ID, ra, 16'h0000, r);
   endtask

   // Failed attempts with the link down
   task automatic fails(input int n);
      repeat (n) begin
         an_fail = 1'b1;
         clks(1);
         an_fail = 1'b0;
         clks(2);
      end
   endtask

   task automatic sreset();
      soft_reset = 1'b1;
      clks(1);
      soft_reset = 1'b0;
      clks(2);
   endtask

   function automatic logic exp_light(logic sel, logic g, logic w, logic l);
      return second_receive_data_pin ? (sel ? g : w) : l;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rstn, soft_reset, link_up, an_fail, rx_error, speed_10m} = '0;
      {tx_pending, rx_dv, crs_dv, gen_irq, wake_irq, led_status} = '0;
      clk_dir_strap = $random(seed);
      second_receive_data_pin = $random(seed);
      clks(10);
      rstn = 1'b1;
      clks(4);
      chk(clk_dir_input, clk_dir_strap);
      rdr(REG_SPEED_CFG);
      chk(r, SPEED_CFG_RST);
      rdr(REG_RX_ERR);
      chk(r, 16'h0000);
      rdr(REG_EXT_ADDR);
      chk(r, 16'h0000);
      // A frame for another station leaves the line pulled up
      host_u.frame(OP_READ, PHY_ID ^ 5'h01, REG_SPEED_CFG, 16'h0000, r);
      chk(r, 16'hFFFF);
      wr(REG_SPEED_CFG, 16'hFFFF);
      rdr(REG_SPEED_CFG);
      chk(r, SPEED_CFG_WMASK);
      wr(REG_RX_ERR, 16'h1234);
      rdr(REG_RX_ERR);
      chk(r, 16'h0000);
      // Receive errors count; the line then stays busy to reach the top
      rx_error = 1'b1;
      clks(7);
      rx_error = 1'b0;
      rdr(REG_RX_ERR);
      chk(r, 16'h0007);
      rx_error = 1'b1;
      // Idle transmitter power control
      wr(REG_EXT_ADDR, EXT_TEN_MEG_PWR);
      rdr(REG_EXTENDED_DATA_PORT);
      chk(r, TEN_MEG_PWR_RST);
      rdr(REG_EXT_ADDR);
      chk(r, EXT_TEN_MEG_PWR);
      wr(REG_EXTENDED_DATA_PORT, TEN_MEG_PWR_RST | 16'h0400);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) wr(REG_EXTENDED_DATA_PORT, TEN_MEG_PWR_RST);
         {speed_10m, tx_pending} = i[1:0];
         clks(2);
         chk(tx_dac_on, !(i < 4 && speed_10m && !tx_pending));
      end
      // Combo control: random values covering every interface mode
      wr(REG_EXT_ADDR, EXT_COMBO_CTRL);
      rdr(REG_EXTENDED_DATA_PORT);
      chk(r, {15'h0000, clk_dir_strap});
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         if (i < 4) {v[4], v[1:0]} = {i[0], i[1:0]};
         wr(REG_EXTENDED_DATA_PORT, v);
         rdr(REG_EXTENDED_DATA_PORT);
         chk(r, v);
         chk({remote_loopback, wake_packet_enable}, {v[11], v[2]});
         chk(max_frame_len, v[5] ? FRAME_MAX_LARGE : FRAME_MAX_SMALL);
         chk({reduced_mode_one, reduced_mode_two, clk_dir_input},
            {v[1] & v[0], v[1] & ~v[0], v[0]});
         rx_dv = $random(seed);
         crs_dv = $random(seed);
         clks(2);
         chk(crs_dv_pin, (v[1] && v[4]) ? rx_dv : crs_dv);
      end
      // Unknown extended address drops writes and reads zero
      wr(REG_EXT_ADDR, 16'h1234);
      wr(REG_EXTENDED_DATA_PORT, 16'h5555);
      rdr(REG_EXTENDED_DATA_PORT);
      chk(r, 16'h0000);
      // Interrupt routing to the shared light pin
      wr(REG_EXT_ADDR, EXT_PAD_CTRL);
      rdr(REG_EXTENDED_DATA_PORT);
      chk(r, PAD_CTRL_RST);
      for (int i = 0; i < 4; i++) begin
         wr(REG_EXTENDED_DATA_PORT, {i[0], 15'h00EF});
         {gen_irq, wake_irq, led_status} = $random(seed);
         clks(2);
         chk(first_status_light_pin,
            exp_light(i[0], gen_irq, wake_irq, led_status));
      end
      // Downgrade: new count waits for soft reset, five tries by default
      wr(REG_SPEED_CFG, SPEED_CFG_RST);
      sreset();
      wr(REG_SPEED_CFG, 16'h0820);
      fails(4);
      chk(speed_downgrade, 1'b0);
      fails(1);
      chk(speed_downgrade, 1'b1);
      sreset();
      chk(speed_downgrade, 1'b0);
      fails(1);
      link_up = 1'b1;
      clks(10);
      link_up = 1'b0;
      clks(3);
      chk(speed_downgrade, 1'b1);
      // Bypassed timer makes a short link a success
      wr(REG_SPEED_CFG, 16'h0822);
      sreset();
      fails(1);
      link_up = 1'b1;
      clks(5);
      link_up = 1'b0;
      fails(1);
      chk(speed_downgrade, 1'b0);
      wr(REG_SPEED_CFG, 16'h0800);
      fails(2);
      chk(speed_downgrade, 1'b1);
      sreset();
      fails(3);
      chk(speed_downgrade, 1'b0);
      // Short link with downgrade off still counts a retry
      link_up = 1'b1;
      clks(3);
      link_up = 1'b0;
      clks(2);
      chk(speed_downgrade, 1'b0);
      // Error tally has run past its top by now and holds there
      clks(33000);
      rx_error = 1'b0;
      rdr(REG_RX_ERR);
      chk(r, RX_ERR_MAX);
      test_done();
   end
endmodule // phy_mgmt_config_regs_tb
`default_nettype wire
